// ### logic/fws_regs.vh
// Register offsets, fields and timing counts of the flash status poller
`ifndef FWS_REGS_VH
`define FWS_REGS_VH
// APB register byte offsets
`define FWS_CTRL_OFF 12'h000
`define FWS_ADDR_OFF 12'h004
`define FWS_DATA_OFF 12'h008
`define FWS_STAT_OFF 12'h00c
`define FWS_RDAT_OFF 12'h010
// Control register fields
`define FWS_CTRL_START 0
`define FWS_CTRL_CMD_LO 1
`define FWS_CTRL_CMD_HI 3
`define FWS_CTRL_RESUME 4
// Commands
`define FWS_CMD_READ 3'h0
`define FWS_CMD_WRITE 3'h1
`define FWS_CMD_POLL 3'h2
`define FWS_CMD_RESET 3'h3
`define FWS_CMD_SECT 3'h4
// Status register fields
`define FWS_ST_BUSY 0
`define FWS_ST_DONE 1
`define FWS_ST_PASS 2
`define FWS_ST_FAIL 3
`define FWS_ST_TIMER 4
`define FWS_ST_REFUSED 5
`define FWS_ST_PENDING 6
`define FWS_ST_RYBY 7
// Status bit positions on the flash data bus
`define FWS_DQ_POLL 7
`define FWS_DQ_TOG1 6
`define FWS_DQ_LIMIT 5
`define FWS_DQ_TIMER 3
`define FWS_DQ_TOG2 2
// Flash reset command byte
`define FWS_RESET_BYTE 8'hf0
// Bus cycle length: 70 ns access rounded up at 50 ns per cycle
`define FWS_T_ACC_NS 70
`define FWS_CLK_NS 50
`define FWS_ACC_CYC ((`FWS_T_ACC_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
// Sector erase command spacing limit, 50 us, rounded down
`define FWS_T_SECT_NS 50000
`define FWS_SECT_CYC (`FWS_T_SECT_NS / `FWS_CLK_NS)
`endif

// ### logic/fws_poller.v
// Host-side flash write-status poller, software-driven over APB
// Operation
// - Read status twice, compare toggle bit
// - Toggle stable means done; array readable next
// - Toggling with limit flag: recheck toggle once
// - Failure: write reset command to flash
// - Toggling, flag low: repoll or restart later
// - Skip timer check only if under 50us
// - Confirm acceptance, check timer before and after
// - Status valid only at valid address
`timescale 1ns/1ps
`include "fws_regs.vh"
module fws_poller (
  // Clock and reset
  input wire clk_sys_in,
  input wire resetn_in,
  // APB slave
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  // Flash pins
  output reg [18:0] flash_addr_out,
  input wire [7:0] flash_dq_in,
  output reg [7:0] flash_dq_out,
  output reg flash_dq_oe_out,
  output reg flash_cen_out,
  output reg flash_oen_out,
  output reg flash_wen_out,
  input wire ready_busy_in
);
  // Sequencer states
  localparam ST_IDLE = 3'd0;
  localparam ST_RD = 3'd1;
  localparam ST_WR = 3'd2;
  localparam ST_EVAL = 3'd3;
  localparam ST_DONE = 3'd4;
  // Poll phases; PH_TIMER is the sector command's pre-check
  localparam PH_FIRST = 2'd0;
  localparam PH_SECOND = 2'd1;
  localparam PH_RECHK = 2'd2;
  localparam PH_TIMER = 2'd3;

  // Sequencer state and latched command
  reg [2:0] state;
  reg [1:0] phase;
  reg [2:0] cmd;
  // Software-written address and data byte
  reg [18:0] addr_reg;
  reg [7:0] data_reg;
  // Last byte read and the first read of a toggle pair
  reg [7:0] rdat;
  reg [7:0] first_rd;
  // Flash cycle length counter
  reg [2:0] cyc;
  // Status flags as seen in the status register, and the internal sector timer_before flag
  reg busy, done, pass, fail, timer, refused, pending, timer_before;
  // Cycles since the last added sector command, and its spacing verdict
  reg [15:0] sect_gap;
  reg gap_long;
  // Registered ready/busy pin
  reg ryby_s;
  // APB decode
  wire apb_acc;
  wire apb_wr;
  wire [31:0] stat_word;

  // Toggle bit differs between two status reads
  function toggled;
    input [7:0] a;
    input [7:0] b;
    begin
      toggled = a[`FWS_DQ_TOG1] ^ b[`FWS_DQ_TOG1];
    end
  endfunction

  // Reads are captured at the access edge, writes land as pready is seen
  assign apb_acc = psel_in & penable_in & ~pready_out;
  assign apb_wr = psel_in & penable_in & pready_out & pwrite_in;
  // Status word, bit 7 being the registered ready/busy pin
  assign stat_word = {24'h0, ryby_s, pending, refused, timer, fail, pass, done, busy};

  ////////////////////////////////////////////////////////////////////////////
  // APB response: one wait cycle, answer on the second access edge
  always @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0;
    end else begin
      pready_out <= apb_acc;
      pslverr_out <= 1'b0;
      if (apb_acc) begin
        case (paddr_in)
          `FWS_CTRL_OFF: prdata_out <= {27'h0, 1'b0, cmd, 1'b0};
          `FWS_ADDR_OFF: prdata_out <= {13'h0, addr_reg};
          `FWS_DATA_OFF: prdata_out <= {24'h0, data_reg};
          `FWS_STAT_OFF: prdata_out <= stat_word;
          `FWS_RDAT_OFF: prdata_out <= {24'h0, rdat};
          default: begin
            prdata_out <= 32'h0;
            pslverr_out <= 1'b1; // Unmapped address
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flash sequencer
  always @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= ST_IDLE;
      phase <= PH_FIRST;
      cmd <= `FWS_CMD_READ;
      addr_reg <= 19'h0;
      data_reg <= 8'h0;
      rdat <= 8'h0;
      first_rd <= 8'h0;
      cyc <= 3'h0;
      busy <= 1'b0;
      done <= 1'b0;
      pass <= 1'b0;
      fail <= 1'b0;
      timer <= 1'b0;
      refused <= 1'b0;
      pending <= 1'b0;
      timer_before <= 1'b0;
      sect_gap <= 16'hffff;
      gap_long <= 1'b0;
      ryby_s <= 1'b1;
      flash_addr_out <= 19'h0;
      flash_dq_out <= 8'h0;
      flash_dq_oe_out <= 1'b0;
      flash_cen_out <= 1'b1;
      flash_oen_out <= 1'b1;
      flash_wen_out <= 1'b1;
    end else begin
      ryby_s <= ready_busy_in;
      // Time since last sector command, saturating
      if (sect_gap != 16'hffff)
        sect_gap <= sect_gap + 16'h1;
      if (apb_wr && paddr_in == `FWS_ADDR_OFF)
        addr_reg <= pwdata_in[18:0]; // Poll address must be a valid one
      if (apb_wr && paddr_in == `FWS_DATA_OFF)
        data_reg <= pwdata_in[7:0];
      // Refused cleared by writing 1; a set later in this block wins
      if (apb_wr && paddr_in == `FWS_STAT_OFF && pwdata_in[`FWS_ST_REFUSED])
        refused <= 1'b0;
      case (state)
        // Wait for a start written to the control register
        ST_IDLE: begin
          if (apb_wr && paddr_in == `FWS_CTRL_OFF && pwdata_in[`FWS_CTRL_START]) begin
            cmd <= pwdata_in[`FWS_CTRL_CMD_HI:`FWS_CTRL_CMD_LO];
            busy <= 1'b1;
            done <= 1'b0;
            cyc <= 3'h0;
            flash_addr_out <= addr_reg;
            flash_cen_out <= 1'b0;
            // A returning poll always restarts at the double read
            phase <= PH_FIRST;
            if (pwdata_in[`FWS_CTRL_CMD_HI:`FWS_CTRL_CMD_LO] == `FWS_CMD_READ ||
                pwdata_in[`FWS_CTRL_CMD_HI:`FWS_CTRL_CMD_LO] == `FWS_CMD_POLL) begin
              state <= ST_RD;
              flash_oen_out <= 1'b0;
              pass <= 1'b0;
              fail <= 1'b0;
              pending <= 1'b0;
            end else if (pwdata_in[`FWS_CTRL_CMD_HI:`FWS_CTRL_CMD_LO] == `FWS_CMD_SECT) begin
              // Sector command: sample timer bit first
              state <= ST_RD;
              phase <= PH_TIMER;
              flash_oen_out <= 1'b0;
            end else begin
              state <= ST_WR;
              flash_wen_out <= 1'b0;
              flash_dq_oe_out <= 1'b1;
              flash_dq_out <= (pwdata_in[`FWS_CTRL_CMD_HI:`FWS_CTRL_CMD_LO] ==
                `FWS_CMD_RESET) ? `FWS_RESET_BYTE : data_reg;
            end
          end
        end
        // Fixed-length read; a slower part needs a larger count
        ST_RD: begin
          cyc <= cyc + 3'h1;
          if (cyc == `FWS_ACC_CYC) begin
            flash_oen_out <= 1'b1;
            flash_cen_out <= 1'b1;
            rdat <= flash_dq_in;
            cyc <= 3'h0;
            state <= ST_EVAL;
          end
        end
        // Hold a write cycle; the part latches data as the strobe rises
        ST_WR: begin
          cyc <= cyc + 3'h1;
          if (cyc == `FWS_ACC_CYC) begin
            flash_wen_out <= 1'b1;
            flash_cen_out <= 1'b1;
            flash_dq_oe_out <= 1'b0;
            cyc <= 3'h0;
            state <= ST_DONE;
          end
        end
        // Judge the byte just read
        ST_EVAL: begin
          state <= ST_DONE;
          if (cmd == `FWS_CMD_POLL) begin
            case (phase)
              PH_FIRST: begin
                first_rd <= rdat; // Keep first read
                phase <= PH_SECOND;
                state <= ST_RD;
                flash_cen_out <= 1'b0;
                flash_oen_out <= 1'b0;
              end
              PH_SECOND: begin
                timer <= rdat[`FWS_DQ_TIMER];
                if (!toggled(first_rd, rdat)) begin
                  pass <= 1'b1; // Stable toggle: finished
                end else if (rdat[`FWS_DQ_LIMIT]) begin
                  first_rd <= rdat; // Limit flag high: look once more
                  phase <= PH_RECHK;
                  state <= ST_RD;
                  flash_cen_out <= 1'b0;
                  flash_oen_out <= 1'b0;
                end else begin
                  pending <= 1'b1; // Still running, software repolls
                end
              end
              PH_RECHK: begin
                if (toggled(first_rd, rdat))
                  fail <= 1'b1; // Needs reset command
                else
                  pass <= 1'b1;
              end
              default: begin
                pass <= 1'b0;
              end
            endcase
          end else if (cmd == `FWS_CMD_SECT) begin
            timer <= rdat[`FWS_DQ_TIMER];
            if (phase == PH_TIMER) begin
              timer_before <= rdat[`FWS_DQ_TIMER];
              if (rdat[`FWS_DQ_TIMER])
                refused <= 1'b1; // Erase begun, command would be ignored
              else begin
                // Timer open: issue added sector command
                phase <= PH_SECOND;
                state <= ST_WR;
                flash_cen_out <= 1'b0;
                flash_wen_out <= 1'b0;
                flash_dq_oe_out <= 1'b1;
                flash_dq_out <= data_reg;
                gap_long <= (sect_gap > `FWS_SECT_CYC); // Spacing from the previous one
                sect_gap <= 16'h0;
              end
            end else begin
              // Second check high: command may be lost
              if (rdat[`FWS_DQ_TIMER] && gap_long)
                refused <= 1'b1; // Under 50 us spacing is safe
            end
          end
        end
        // Either the sector recheck or the end of the command
        ST_DONE: begin
          if (cmd == `FWS_CMD_SECT && phase == PH_SECOND && !timer_before) begin
            // Post-command timer read
            timer_before <= 1'b1;
            state <= ST_RD;
            phase <= PH_RECHK;
            flash_cen_out <= 1'b0;
            flash_oen_out <= 1'b0;
          end else begin
            busy <= 1'b0;
            done <= 1'b1;
            timer_before <= 1'b0;
            if (cmd == `FWS_CMD_RESET) begin
              fail <= 1'b0;
              pending <= 1'b0;
            end
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // fws_poller

// ### tb/fws_poller_monitor.sv
// Port checker for the flash status poller
`timescale 1ns/1ps
module fws_poller_monitor (
  // Clock, reset and APB
  input wire clk_sys_in, resetn_in, psel_in, penable_in, pready_out, pslverr_out,
  input wire [31:0] prdata_out,
  // Flash pins
  input wire [18:0] flash_addr_out,
  input wire [7:0] flash_dq_out,
  input wire flash_dq_oe_out, flash_cen_out, flash_oen_out, flash_wen_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  ////////////////////
  // APB answers after one wait state, for one cycle
  property p_apb_wait; psel_in && penable_in && !pready_out |=> pready_out; endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("pready not after one wait");
  property p_apb_pulse; pready_out |=> !pready_out; endproperty
  a_apb_pulse: assert property (p_apb_pulse) else $error("pready longer than a cycle");
  property p_err_zero; pready_out && pslverr_out |-> prdata_out == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read not zero");
  // Whole read cycles, so two reads really are two
  property p_rd_cycle; $fell(flash_cen_out) |-> !flash_cen_out [*3] ##1 flash_cen_out; endproperty
  a_rd_cycle: assert property (p_rd_cycle) else $error("flash cycle length");
  // Never fight the device on the data bus
  property p_no_fight; !flash_oen_out |-> !flash_dq_oe_out; endproperty
  a_no_fight: assert property (p_no_fight) else $error("bus contention");
  property p_wr_drive; !flash_wen_out |-> !flash_cen_out && flash_oen_out && flash_dq_oe_out;
  endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("bad write strobes");
  // Status is only valid at a held address
  property p_addr_hold; !flash_cen_out ##1 !flash_cen_out |-> $stable(flash_addr_out);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved");
  property p_wr_data; !flash_wen_out ##1 !flash_wen_out |-> $stable(flash_dq_out); endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data moved");
  c_reset_byte: cover property (!flash_wen_out && flash_dq_out == 8'hf0);
  c_err: cover property (pready_out && pslverr_out);
  c_read: cover property ($fell(flash_cen_out) && flash_wen_out);
endmodule // fws_poller_monitor
bind fws_poller fws_poller_monitor mon (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
  .psel_in(psel_in), .penable_in(penable_in), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .prdata_out(prdata_out), .flash_addr_out(flash_addr_out),
  .flash_dq_out(flash_dq_out), .flash_dq_oe_out(flash_dq_oe_out),
  .flash_cen_out(flash_cen_out), .flash_oen_out(flash_oen_out), .flash_wen_out(flash_wen_out));

// ### tb/fws_flash_model.sv
// Behavioural flash device answering status reads
`timescale 1ns/1ps
module fws_flash_model #(parameter int PROG_READS = 2, parameter int WINDOW = 200) (
  input wire clk_in,
  input wire [18:0] addr_in,
  input wire [7:0] dq_in,
  input wire cen_in, oen_in, wen_in,
  input wire [1:0] mode_in,
  output logic [7:0] dq_out,
  output logic ready_busy_out
);
  logic [7:0] stat, last = 0, pd = 0;
  logic tog = 0, fail = 0, sect = 0, prd = 0, pwe = 1;
  int left = 0, win = 0, reads = 0, still = 0;
  logic [7:0] wd = 0;
  logic [18:0] pa = 0;
  wire rd = !cen_in && !oen_in;
  // Asleep once the address has stood two clocks
  wire asleep = still >= 2;
  // Status while busy, array data otherwise; mode 3 reads a suspended sector
  always_comb begin
    if (mode_in == 2'd3) stat = {1'b1, 1'b0, 1'b0, 2'b00, tog, 2'b00};
    else if (fail) stat = {~pd[7], tog, 6'h20};
    else if (sect) stat = {1'b0, tog, 2'b00, win == 0, tog, 2'b00};
    else if (left != 0) stat = {~pd[7], tog, 6'h00};
    else stat = addr_in[7:0] ^ 8'h5a;
  end
  assign ready_busy_out = mode_in == 2'd3 || !(fail || sect || left != 0);
  // Released bus shows no stale value
  assign dq_out = rd ? stat : ~last;
  ////////////////////
  // Toggle per read; writes start or stop operations
  always @(posedge clk_in) begin
    prd <= rd;
    pwe <= wen_in;
    if (rd) last <= stat;
    if (win != 0) win <= win - 1;
    if (prd && !rd) begin
      tog <= ~tog;
      reads <= reads + 1;
      if (left != 0) left <= left - 1;
    end
    pa <= addr_in;
    if (addr_in != pa) still <= 0;
    else if (still < 3) still <= still + 1;
    // Data is latched while the strobe is low; the host lets go as it rises
    if (!wen_in) wd <= dq_in;
    if (wen_in && !pwe && !(sect && win == 0)) begin
      if (wd == 8'hf0) begin
        fail <= 0;
        left <= 0;
      end else if (wd == 8'h30) begin
        sect <= 1;
        win <= WINDOW;
      end else if (mode_in == 2'd1) begin
        left <= PROG_READS;
        pd <= wd;
      end else if (mode_in == 2'd2) begin
        fail <= 1;
        pd <= wd;
      end
    end
  end
endmodule // fws_flash_model

// ### tb/fws_poller_bench.sv
// Self-checking bench for the flash status poller
`timescale 1ns/1ps
`include "fws_regs.vh"
module fws_poller_bench;
  logic clk_sys_in = 0, resetn_in = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdat;
  logic pready, pslverr, rerr, dq_oe, cen, oen, wen, rb;
  logic [18:0] faddr;
  logic [7:0] dq_drv, mdq;
  logic [1:0] mode = 0;
  int miscompares = 0, checks = 0, n0;
  wire [7:0] dq_bus = dq_oe ? dq_drv : mdq;
  always #25 clk_sys_in = ~clk_sys_in;
  fws_poller uut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .flash_addr_out(faddr), .flash_dq_in(dq_bus), .flash_dq_out(dq_drv),
    .flash_dq_oe_out(dq_oe), .flash_cen_out(cen), .flash_oen_out(oen),
    .flash_wen_out(wen), .ready_busy_in(rb));
  fws_flash_model fl (.clk_in(clk_sys_in), .addr_in(faddr), .dq_in(dq_bus), .cen_in(cen),
    .oen_in(oen), .wen_in(wen), .mode_in(mode), .dq_out(mdq), .ready_busy_out(rb));
  ////////////////////
  task automatic chk(input string s, input [31:0] x, input [31:0] g);
    checks++;
    if (g !== x) begin
      miscompares++;
      $display("Error %s expected %h seen %h", s, x, g);
    end
  endtask
  // Bus values read before the edge's own updates land
  task automatic apb(input w, input [11:0] a, input [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1;
    do begin
      @(posedge clk_sys_in);
      n = n + 1;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) miscompares++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk_sys_in);
  endtask
  task automatic rd(input [11:0] a, input [31:0] m, input [31:0] x);
    apb(0, a, 0);
    chk("apb read", x, rdat & m);
  endtask
  // Start a command, then poll busy under a bound
  task automatic run(input [2:0] c);
    int n;
    n = 0;
    apb(1, `FWS_CTRL_OFF, {28'h0, c, 1'b1});
    do begin
      apb(0, `FWS_STAT_OFF, 0);
      n = n + 1;
    end while (rdat[0] !== 1'b0 && n < 100);
    chk("busy clear", 32'h0, {31'h0, rdat[0]});
  endtask
  task automatic final_report;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    miscompares++;
    final_report;
  end
  ////////////////////
  initial begin
    repeat (5) @(posedge clk_sys_in);
    resetn_in <= 1;
    rd(`FWS_STAT_OFF, 32'hff, 32'h80);
    rd(12'h020, 32'hffffffff, 32'h0);
    chk("slave error", 32'h1, {31'h0, rerr});
    apb(1, `FWS_ADDR_OFF, 32'h12);
    run(`FWS_CMD_READ);
    rd(`FWS_RDAT_OFF, 32'hff, 32'h48);
    chk("flash asleep", 32'h1, {31'h0, fl.asleep});
    $display("test idle done");
    mode <= 1;
    apb(1, `FWS_DATA_OFF, 32'h80);
    run(`FWS_CMD_WRITE);
    n0 = fl.reads;
    run(`FWS_CMD_POLL);
    chk("flash reads", 32'd2, fl.reads - n0);
    rd(`FWS_STAT_OFF, 32'h4e, 32'h42);
    run(`FWS_CMD_POLL);
    rd(`FWS_STAT_OFF, 32'h4e, 32'h06);
    $display("test program done");
    mode <= 2;
    run(`FWS_CMD_WRITE);
    n0 = fl.reads;
    run(`FWS_CMD_POLL);
    chk("flash reads", 32'd3, fl.reads - n0);
    rd(`FWS_STAT_OFF, 32'h8e, 32'h0a);
    run(`FWS_CMD_RESET);
    rd(`FWS_STAT_OFF, 32'h88, 32'h80);
    mode <= 0;
    $display("test failure done");
    apb(1, `FWS_DATA_OFF, 32'h30);
    run(`FWS_CMD_WRITE);
    run(`FWS_CMD_SECT);
    rd(`FWS_STAT_OFF, 32'h30, 32'h00);
    repeat (300) @(posedge clk_sys_in);
    run(`FWS_CMD_SECT);
    rd(`FWS_STAT_OFF, 32'h30, 32'h30);
    apb(1, `FWS_STAT_OFF, 32'h20);
    rd(`FWS_STAT_OFF, 32'h20, 32'h00);
    $display("test sector done");
    mode <= 3;
    run(`FWS_CMD_POLL);
    rd(`FWS_STAT_OFF, 32'h9e, 32'h86);
    $display("test suspend done");
    final_report;
  end
endmodule // fws_poller_bench
